// File: hdl/dam_defines.svh
`ifndef DAM_DEFINES_SVH
`define DAM_DEFINES_SVH

// digit code layout: quinary in [2:0], binary half in [3], even in [4]
`define DAM_DIGITS    5
`define DAM_CODE_W    5
`define DAM_ADDR_W    25
`define DAM_Q_W       3
`define DAM_HALF_BIT  3
`define DAM_EVEN_BIT  4
`define DAM_BQ_W      7
`define DAM_BQ_LO_BIT 5
`define DAM_BQ_HI_BIT 6

// one-hot modification select positions
`define DAM_SEL_W       6
`define DAM_SEL_P00001  0
`define DAM_SEL_P97501  1
`define DAM_SEL_M00001  2
`define DAM_SEL_M00009  3
`define DAM_SEL_M00010  4
`define DAM_SEL_M00021  5

// digit values and pre-translation offsets
`define DAM_NINE    4'h9
`define DAM_ZERO    4'h0
`define DAM_FIVE    4'h5
`define DAM_TEN     5'h0A
`define DAM_NONE    4'h0
`define DAM_ONE     4'h1
`define DAM_TR_DN2  4'h2
`define DAM_TR_UP5  4'h5
`define DAM_TR_UP7  4'h7

// storage time of the modified digits before forwarding
`define DAM_CLK_NS   25
`define DAM_HOLD_NS  2000
`define DAM_HOLD_CYC (`DAM_HOLD_NS / `DAM_CLK_NS)
`define DAM_CNT_W    7

`endif

// File: hdl/dam_pkg.sv
`include "dam_defines.svh"

package dam_pkg;

	typedef enum logic [2:0] {
		DAM_IDLE  = 3'b001,
		DAM_FIFTH = 3'b010,
		DAM_HOLD  = 3'b100
	} dam_state_type;

	typedef struct packed {
		logic [3:0] value;
		logic       carry;
		logic       borrow;
	} dam_step_type;

	typedef struct packed {
		dam_state_type                state;
		logic [`DAM_CNT_W-1:0]        cnt;
		logic [`DAM_SEL_W-1:0]        sel;
		logic [`DAM_CODE_W-1:0]       d5_in;
		logic                         chg4;
		logic [`DAM_CODE_W-1:0]       ff1;
		logic [`DAM_CODE_W-1:0]       ff2;
		logic [`DAM_CODE_W-1:0]       ff3;
		logic [`DAM_BQ_W-1:0]         bq4;
		logic [`DAM_CODE_W-1:0]       ff5;
		logic                         wr_valid;
		logic [`DAM_ADDR_W-1:0]       wr_addr;
	} dam_regs_type;

endpackage

// File: hdl/dam_modifier.sv
// Notes on behaviour
// RL1: after offsets, every digit only steps up one, down one, or holds.
// RL2: digit 1 acts directly on the selected modifier, ignoring any carry.
// RL3: digits 2..4, and digit 5 except under plus-97501, step up on carry, down on borrow, else hold.
// RL4: minus-ten always makes digit 1 send a borrow to digit 2.
// RL5: digits 1 and 3 tell the next digit carry, borrow or no change.
// RL6: digit 1 carries only under plus-one or plus-97501 with digit nine.
// RL7: digits 2 and 4 send only change; its sense follows the modification.
// RL8: plus-97501 with a carry out of digit 4 holds digit 5.
// RL9: plus-97501 without a carry out of digit 4 decrements digit 5.
// RL10: digit 1 half flop sets for results five to nine.
// RL11: digits 1,3,4,5 set their half flop for results five to nine.
// RL12: digit 2 half flop sets for results zero to four, inverted at output.
// RL13: half detection covers original digit, step and translation offset.
// RL14: digits 1 and 5 set parity flop on even results.
// RL15: digits 2 and 3 set parity flop on odd results, inverted at output.
// RL16: parity follows original parity and oddness of the total change.
// RL17: digit 4 is held in seven biquinary flops for the hold time.
// RL18: digit 4 goes back to register code only where the write word forms.
// RL19: digit 1 borrows: -9 not nine, -1/-21 at zero, always -10.
// RL20: offsets: +97501 gives digit 3 +5, digit 4 +7; -21 gives digit 2 -2.
`timescale 1ns/1ps
`include "dam_defines.svh"

module dam_modifier (
	input  wire logic                   clk,      // 40 MHz clock
	input  wire logic                   sys_rst,  // sync reset, high
	input  wire logic                   start,    // take address and select
	input  wire logic [`DAM_ADDR_W-1:0] addr_in,  // five coded digits
	input  wire logic [`DAM_SEL_W-1:0]  mod_sel,  // one-hot modification
	output logic                        busy,     // modification in progress
	output logic [`DAM_BQ_W-1:0]        hold_bq4, // digit 4 biquinary store
	output logic                        wr_valid, // write word strobe
	output logic [`DAM_ADDR_W-1:0]      wr_addr   // modified address
);

	dam_pkg::dam_regs_type r_q;
	dam_pkg::dam_regs_type r_d;

	function automatic logic [3:0] code_to_val(
		input logic [`DAM_CODE_W-1:0] c
	);
		logic [3:0] q;
		q = {1'b0, c[`DAM_Q_W-1:0]};
		code_to_val = c[`DAM_HALF_BIT] ? q + `DAM_FIVE : q;
	endfunction

	// one step of wrap-around decimal shift by up or down amount
	// up and down stay below ten, so one wrap each way is enough
	function automatic dam_pkg::dam_step_type shift_digit(
		input logic [3:0] v,
		input logic [3:0] up,
		input logic [3:0] dn
	);
		logic [4:0]            s;
		dam_pkg::dam_step_type o;
		s = {1'b0, v} + {1'b0, up};
		o.carry = 1'b0;
		o.borrow = 1'b0;
		if (s >= `DAM_TEN)
		begin
			o.carry = 1'b1;
			s = s - `DAM_TEN;
		end
		if (s < {1'b0, dn})
		begin
			o.borrow = 1'b1;
			s = s + `DAM_TEN;
		end
		s = s - {1'b0, dn};
		o.value = s[3:0];
		return o;
	endfunction

	// offset first, then a single +1/-1/hold
	function automatic dam_pkg::dam_step_type modify_digit(
		input logic [3:0] v,
		input logic [3:0] off_up,
		input logic [3:0] off_dn,
		input logic       inc,
		input logic       dec
	);
		dam_pkg::dam_step_type t;
		dam_pkg::dam_step_type m;
		t = shift_digit(v, off_up, off_dn);
		m = shift_digit(t.value, inc ? `DAM_ONE : `DAM_NONE,
			dec ? `DAM_ONE : `DAM_NONE); // RL1
		m.carry = m.carry | t.carry;
		m.borrow = m.borrow | t.borrow;
		return m;
	endfunction

	// result parity from source parity and oddness of the change
	function automatic logic result_odd(
		input logic [3:0] v,
		input logic [3:0] off_up,
		input logic [3:0] off_dn,
		input logic       changed
	);
		result_odd = v[0] ^ off_up[0] ^ off_dn[0] ^ changed; // RL16
	endfunction

	function automatic logic [`DAM_Q_W-1:0] quinary(input logic [3:0] v);
		logic [3:0] q;
		q = (v >= `DAM_FIVE) ? v - `DAM_FIVE : v;
		quinary = q[`DAM_Q_W-1:0];
	endfunction

	// flop image to register code; some stages store inverted senses
	function automatic logic [`DAM_CODE_W-1:0] flops_to_code(
		input logic [`DAM_CODE_W-1:0] f,
		input logic                   inv_half,
		input logic                   inv_par
	);
		flops_to_code = {f[`DAM_EVEN_BIT] ^ inv_par,
			f[`DAM_HALF_BIT] ^ inv_half, f[`DAM_Q_W-1:0]};
	endfunction

	function automatic logic [`DAM_BQ_W-1:0] val_to_bq(input logic [3:0] v);
		logic [`DAM_BQ_W-1:0] b;
		b = '0;
		b[quinary(v)] = 1'b1;
		if (v >= `DAM_FIVE)
			b[`DAM_BQ_HI_BIT] = 1'b1;
		else
			b[`DAM_BQ_LO_BIT] = 1'b1;
		return b;
	endfunction

	function automatic logic [`DAM_CODE_W-1:0] bq_to_code(
		input logic [`DAM_BQ_W-1:0] b
	);
		logic [`DAM_Q_W-1:0] q;
		logic [3:0]          v;
		// an empty quinary group reads as zero rather than unknown
		q = '0;
		for (int i = 0; i < 5; i++)
			if (b[i])
				q = i[`DAM_Q_W-1:0];
		v = b[`DAM_BQ_HI_BIT] ? {1'b0, q} + `DAM_FIVE : {1'b0, q};
		bq_to_code = {~v[0], b[`DAM_BQ_HI_BIT], q};
	endfunction

	logic                  sel_p1;
	logic                  sel_p97;
	logic                  sel_m1;
	logic                  sel_m9;
	logic                  sel_m10;
	logic                  sel_m21;
	logic                  additive;
	logic [3:0]            v1;
	logic [3:0]            v2;
	logic [3:0]            v3;
	logic [3:0]            v4;
	logic [3:0]            v5;
	logic [3:0]            up3;
	logic [3:0]            up4;
	logic [3:0]            dn2;
	logic                  inc1;
	logic                  dec1;
	logic                  inc2;
	logic                  dec2;
	logic                  digit1_carry_next;
	logic                  digit1_borrow_next;
	logic                  digit1_hold_next;
	logic                  digit2_change_next;
	logic                  inc3;
	logic                  dec3;
	logic                  inc4;
	logic                  dec4;
	logic                  inc5;
	logic                  dec5;
	logic                  add5;
	logic                  chg4;
	dam_pkg::dam_step_type s1;
	dam_pkg::dam_step_type s2;
	dam_pkg::dam_step_type s3;
	dam_pkg::dam_step_type s4;
	dam_pkg::dam_step_type s5;
	logic [`DAM_CODE_W-1:0] img1;
	logic [`DAM_CODE_W-1:0] img2;
	logic [`DAM_CODE_W-1:0] img3;
	logic [`DAM_CODE_W-1:0] img5;
	logic [`DAM_CODE_W-1:0] out1;
	logic [`DAM_CODE_W-1:0] out2;
	logic [`DAM_CODE_W-1:0] out3;
	logic [`DAM_CODE_W-1:0] out4;
	logic [`DAM_CODE_W-1:0] out5;

	// digits 1..4 act on the live inputs in the start cycle
	always_comb
	begin
		// a select with two or more bits set is undefined and not guarded
		sel_p1  = mod_sel[`DAM_SEL_P00001];
		sel_p97 = mod_sel[`DAM_SEL_P97501];
		sel_m1  = mod_sel[`DAM_SEL_M00001];
		sel_m9  = mod_sel[`DAM_SEL_M00009];
		sel_m10 = mod_sel[`DAM_SEL_M00010];
		sel_m21 = mod_sel[`DAM_SEL_M00021];
		additive = sel_p1 | sel_p97;
		v1 = code_to_val(addr_in[0 +: `DAM_CODE_W]);
		v2 = code_to_val(addr_in[5 +: `DAM_CODE_W]);
		v3 = code_to_val(addr_in[10 +: `DAM_CODE_W]);
		v4 = code_to_val(addr_in[15 +: `DAM_CODE_W]);
		dn2 = sel_m21 ? `DAM_TR_DN2 : `DAM_NONE; // RL20
		up3 = sel_p97 ? `DAM_TR_UP5 : `DAM_NONE; // RL20
		up4 = sel_p97 ? `DAM_TR_UP7 : `DAM_NONE; // RL20
	end

	// carry chain through digits 1..4 from the decoded selects
	always_comb
	begin

		inc1 = sel_p1 | sel_p97 | sel_m9; // RL2
		dec1 = sel_m1 | sel_m21; // RL2
		s1 = modify_digit(v1, `DAM_NONE, `DAM_NONE, inc1, dec1);
		digit1_carry_next = additive & (v1 == `DAM_NINE); // RL6
		digit1_borrow_next = (sel_m9 & (v1 != `DAM_NINE))
			| ((sel_m1 | sel_m21) & (v1 == `DAM_ZERO))
			| sel_m10; // RL19 RL4
		digit1_hold_next = ~digit1_carry_next & ~digit1_borrow_next; // RL5

		// minus-ten reaches digit 2 as a borrow from digit 1
		inc2 = digit1_carry_next; // RL3
		dec2 = digit1_borrow_next; // RL3 RL4
		s2 = modify_digit(v2, `DAM_NONE, dn2, inc2, dec2); // RL3
		digit2_change_next = s2.carry | s2.borrow; // RL7

		inc3 = digit2_change_next & additive; // RL7
		dec3 = digit2_change_next & ~additive; // RL7
		s3 = modify_digit(v3, up3, `DAM_NONE, inc3, dec3); // RL3

		inc4 = s3.carry; // RL3 RL5
		dec4 = s3.borrow; // RL3 RL5
		s4 = modify_digit(v4, up4, `DAM_NONE, inc4, dec4); // RL3
		chg4 = s4.carry | s4.borrow; // RL7

		img1 = {~result_odd(v1, `DAM_NONE, `DAM_NONE, inc1 | dec1), // RL14
			s1.value >= `DAM_FIVE, quinary(s1.value)}; // RL10 RL11
		img2 = {result_odd(v2, `DAM_NONE, dn2,
				~digit1_hold_next), // RL15
			s2.value < `DAM_FIVE, quinary(s2.value)}; // RL12 RL13
		img3 = {result_odd(v3, up3, `DAM_NONE,
				digit2_change_next), // RL15
			s3.value >= `DAM_FIVE, quinary(s3.value)}; // RL11 RL13
	end

	// digit 5 acts one cycle later on held inputs, like the late stage
	always_comb
	begin
		v5 = code_to_val(r_q.d5_in);
		add5 = r_q.sel[`DAM_SEL_P00001] | r_q.sel[`DAM_SEL_P97501];
		if (r_q.sel[`DAM_SEL_P97501])
		begin
			inc5 = 1'b0; // RL8
			dec5 = ~r_q.chg4; // RL9
		end
		else
		begin
			inc5 = r_q.chg4 & add5; // RL7
			dec5 = r_q.chg4 & ~add5; // RL7
		end
		s5 = modify_digit(v5, `DAM_NONE, `DAM_NONE, inc5, dec5); // RL3
		img5 = {~result_odd(v5, `DAM_NONE, `DAM_NONE, inc5 | dec5), // RL14
			s5.value >= `DAM_FIVE, quinary(s5.value)}; // RL11 RL13
	end

	// stored flop images back to register code; digit 4 converts only here
	always_comb
	begin
		out1 = flops_to_code(r_q.ff1, 1'b0, 1'b0);
		out2 = flops_to_code(r_q.ff2, 1'b1, 1'b1); // RL12 RL15
		out3 = flops_to_code(r_q.ff3, 1'b0, 1'b1); // RL15
		out4 = bq_to_code(r_q.bq4); // RL18
		out5 = flops_to_code(r_q.ff5, 1'b0, 1'b0);
	end

	always_comb
	begin
		r_d = r_q;
		r_d.wr_valid = 1'b0;
		unique case (r_q.state)
			dam_pkg::DAM_IDLE:
			begin
				if (start)
				begin
					// digit 5 works a cycle late, so keep what it needs
					r_d.sel = mod_sel;
					r_d.d5_in = addr_in[20 +: `DAM_CODE_W];
					r_d.chg4 = chg4;
					r_d.ff1 = img1;
					r_d.ff2 = img2;
					r_d.ff3 = img3;
					r_d.bq4 = val_to_bq(s4.value); // RL17
					r_d.cnt = '0;
					r_d.state = dam_pkg::DAM_FIFTH;
				end
			end
			dam_pkg::DAM_FIFTH:
			begin
				r_d.ff5 = img5;
				r_d.cnt = r_q.cnt + 1'b1;
				r_d.state = dam_pkg::DAM_HOLD;
			end
			dam_pkg::DAM_HOLD:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				// storage lasts the full hold time, then one forward
				if (r_q.cnt == `DAM_CNT_W'(`DAM_HOLD_CYC - 1)) // RL17
				begin
					r_d.wr_valid = 1'b1;
					r_d.wr_addr = {out5, out4, out3, out2, out1}; // RL18
					r_d.state = dam_pkg::DAM_IDLE;
				end
			end
			default:
			begin
				r_d.state = dam_pkg::DAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			// outputs read zero; the store is not biquinary until a take
			r_q <= '0;
			r_q.state <= dam_pkg::DAM_IDLE;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	// handshake flag read straight from the state register
	assign busy = (r_q.state != dam_pkg::DAM_IDLE);
	// the store stays readable after the forward, until the next take
	assign hold_bq4 = r_q.bq4;
	assign wr_valid = r_q.wr_valid;
	assign wr_addr = r_q.wr_addr;

endmodule

// File: test/dam_modifier_monitor.sv
`timescale 1ns/1ps
`include "dam_defines.svh"

module dam_mon (
	input  wire logic                   clk,      // clock
	input  wire logic                   sys_rst,  // sync reset
	input  wire logic                   start,    // request
	input  wire logic [`DAM_ADDR_W-1:0] addr_in,  // address in
	input  wire logic [`DAM_SEL_W-1:0]  mod_sel,  // select
	input  wire logic                   busy,     // busy
	input  wire logic [`DAM_BQ_W-1:0]   hold_bq4, // digit 4 store
	input  wire logic                   wr_valid, // strobe
	input  wire logic [`DAM_ADDR_W-1:0] wr_addr   // result
);
	logic [`DAM_ADDR_W-1:0] cap_q;
	logic [`DAM_SEL_W-1:0]  sel_q;
	logic [3:0]             stp;
	logic [3:0]             e1;
	logic                   take;

	function automatic int dv(logic [4:0] c);
		return c[2:0] + (c[3] ? 5 : 0);
	endfunction

	assign take = start && !busy;

	// request lines are released after the take, so keep our own copy
	always_ff @(posedge clk)
	begin
		if (take)
		begin
			cap_q <= addr_in;
			sel_q <= mod_sel;
		end
	end

	always_comb
	begin
		stp = 4'h0;
		if (sel_q[0] | sel_q[1] | sel_q[3])
			stp = 4'h1;
		if (sel_q[2] | sel_q[5])
			stp = 4'h9;
		e1 = 4'((dv(cap_q[4:0]) + stp) % 10);
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_take;
		take;
	endsequence
	sequence s_fwd;
		wr_valid ##1 !wr_valid;
	endsequence

	a_busy_after: assert property (s_take |=> busy[*8])
		else $error("busy not held after take");
	a_fwd_time: assert property (s_take |-> ##81 s_fwd)
		else $error("forward strobe not at cycle 81");
	a_fwd_ends: assert property (wr_valid |-> !busy && $past(busy))
		else $error("strobe without busy ending");
	a_bq4_keep: assert property (busy && $past(busy) |->
		$stable(hold_bq4))
		else $error("digit 4 store moved while busy");
	a_bq4_form: assert property (busy |->
		$onehot(hold_bq4[4:0]) && hold_bq4[6] != hold_bq4[5])
		else $error("digit 4 store not biquinary");
	a_addr_keep: assert property (!wr_valid |-> $stable(wr_addr))
		else $error("result moved without strobe");
	a_low_digit: assert property (wr_valid |-> dv(wr_addr[4:0]) == e1)
		else $error("low digit step wrong");
	a_ten_borrow: assert property (wr_valid && sel_q[4] |->
		dv(wr_addr[9:5]) == (dv(cap_q[9:5]) + 9) % 10)
		else $error("minus ten did not lower digit 2");
	a_no_carry: assert property (wr_valid && sel_q[0] &&
		dv(cap_q[4:0]) != 9 |-> dv(wr_addr[9:5]) == dv(cap_q[9:5]))
		else $error("carry without a nine");
	a_even_bit: assert property (wr_valid |->
		wr_addr[4] == (dv(wr_addr[4:0]) % 2 == 0))
		else $error("low digit even bit wrong");
endmodule

bind dam_modifier dam_mon u_mon (
	.clk      (clk),
	.sys_rst  (sys_rst),
	.start    (start),
	.addr_in  (addr_in),
	.mod_sel  (mod_sel),
	.busy     (busy),
	.hold_bq4 (hold_bq4),
	.wr_valid (wr_valid),
	.wr_addr  (wr_addr)
);

// File: test/dam_src.sv
`timescale 1ns/1ps

module dam_src (
	input  wire logic clk,     // clock
	input  wire logic busy,    // modifier busy
	output logic        start,   // request
	output logic [24:0] addr_in, // coded address
	output logic [5:0]  mod_sel  // one-hot select
);
	initial
	begin
		start = 1'b0;
		addr_in = 25'h000_0000;
		mod_sel = 6'h00;
	end

	task automatic send(input logic [24:0] a, input logic [5:0] s);
		@(posedge clk);
		#1;
		start = 1'b1;
		addr_in = a;
		mod_sel = s;
		while (busy === 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		start = 1'b0;
		// released lines must not look like a still-valid request
		addr_in = ~a;
		mod_sel = ~s;
	endtask
endmodule

// File: test/dam_modifier_tb_top.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module dam_modifier_tb_top;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        start;
	logic [24:0] addr_in;
	logic [5:0]  mod_sel;
	logic        busy;
	logic [6:0]  hold_bq4;
	logic        wr_valid;
	logic [24:0] wr_addr;
	int          errors = 0;
	int          checks_done = 0;

	always #12.5 clk = ~clk;

	dam_modifier u_dut (.clk(clk), .sys_rst(sys_rst), .start(start),
		.addr_in(addr_in), .mod_sel(mod_sel), .busy(busy),
		.hold_bq4(hold_bq4), .wr_valid(wr_valid), .wr_addr(wr_addr));
	dam_src u_src (.clk(clk), .busy(busy), .start(start),
		.addr_in(addr_in), .mod_sel(mod_sel));

	function automatic logic [24:0] enc(int v);
		logic [24:0] r;
		int d;
		for (int i = 0; i < 5; i++)
		begin
			d = v % 10;
			v = v / 10;
			r[i*5 +: 5] = {d % 2 == 0, d >= 5, 3'(d % 5)};
		end
		return r;
	endfunction

	function automatic logic [6:0] bq(int d);
		return {d >= 5, d < 5, 5'(1 << (d % 5))};
	endfunction

	// s is the select position, or -1 for no modification
	task automatic run(int a, int s, int e);
		int n;
		n = 0;
		u_src.send(enc(a), s < 0 ? 6'h00 : 6'(1 << s));
		`CHK(hold_bq4, bq(e / 1000 % 10))
		while (wr_valid !== 1'b1 && n < 90)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(n, 80)
		`CHK(wr_addr, enc(e))
	endtask

	task automatic test_plus;
		run(99, 0, 100);
		run(99999, 0, 0);
		run(12340, 0, 12341);
		run(12345, 1, 9846);
		run(12599, 1, 10100);
		run(2499, 1, 0);
		$display("test plus done");
	endtask

	task automatic test_minus;
		run(5, 4, 99995);
		run(21, 5, 0);
		run(20, 5, 99999);
		run(10, 3, 1);
		run(19, 3, 10);
		run(0, 2, 99999);
		run(100, 2, 99);
		run(12345, -1, 12345);
		$display("test minus done");
	endtask

	task automatic test_reset;
		u_src.send(enc(777), 6'h01);
		repeat (5) @(posedge clk);
		#1;
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(busy, 1'b0)
		`CHK(wr_valid, 1'b0)
		`CHK(hold_bq4, 7'h00)
		`CHK(wr_addr, 25'h000_0000)
		sys_rst = 1'b0;
		run(777, 0, 778);
		$display("test reset done");
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		test_plus();
		test_minus();
		test_reset();
		test_done();
	end

	// about 1250 cycles expected; allow more than three times that
	initial
	begin
		#100000;
		errors++;
		test_done();
	end
endmodule
